// ### include/spi_link_pkg.sv
// Shared constants of the serial converter link: word layout, protocol codes, host register map.
package spi_link_pkg;

    // ****************************************
    // Serial word and protocol codes
    // ****************************************
    localparam int         WORD_BITS      = 22;
    localparam logic [4:0] WORD_COUNT     = 5'h16;
    localparam int         WORD_MSB       = WORD_BITS - 1;
    localparam logic [1:0] MODE_DEFAULT   = 2'h0;
    localparam logic [1:0] OUT_STANDARD   = 2'h0;
    localparam logic [1:0] OUT_EARLY      = 2'h1;
    localparam logic [1:0] OUT_SOURCE     = 2'h3;
    localparam int         MODE_CPOL      = 1;
    localparam int         MODE_CPHA      = 0;

    // ****************************************
    // Command word fields and device registers
    // ****************************************
    localparam int         CMD_MSB        = 21;
    localparam int         CMD_LSB        = 19;
    localparam int         ADDR_MSB       = 15;
    localparam int         ADDR_LSB       = 8;
    localparam int         DATA_MSB       = 7;
    localparam logic [2:0] CMD_WRITE      = 3'h5;
    localparam logic [7:0] ADDR_IN_CTRL   = 8'h10;
    localparam logic [7:0] ADDR_OUT_CTRL  = 8'h12;
    localparam logic [7:0] IN_CTRL_RESET  = 8'h00;
    localparam logic [7:0] OUT_CTRL_RESET = 8'h00;

    // ****************************************
    // Host register map on the system bus
    // ****************************************
    localparam logic [7:0] REG_CTRL       = 8'h00;
    localparam logic [7:0] REG_TX         = 8'h04;
    localparam logic [7:0] REG_RX         = 8'h08;
    localparam logic [7:0] REG_STATUS     = 8'h0c;
    localparam logic [7:0] REG_FRAME_LEN  = 8'h10;
    localparam int         CTRL_START     = 0;
    localparam int         STAT_BUSY      = 0;
    localparam int         STAT_IN_LSB    = 1;
    localparam int         STAT_OUT_LSB   = 3;
    localparam int         LEN_W          = 5;
    localparam logic [4:0] FRAME_LEN_RESET = 5'h16;
    localparam logic [1:0] HTRANS_NONSEQ  = 2'h2;

    // ****************************************
    // Serial clock timing
    // ****************************************
    localparam int         HCLK_PERIOD_NS   = 50;
    localparam int         SCLK_HALF_NS     = 400;
    localparam int         SCLK_HALF_CYCLES = (SCLK_HALF_NS + HCLK_PERIOD_NS - 1) / HCLK_PERIOD_NS;

endpackage

// ### include/spi_link_if.sv
// Serial link between the converter end and its host controller.
`timescale 1ns/100ps
`default_nettype none
interface spi_link_if;
    logic cs_n;
    logic sclk;
    logic sdi;
    logic sdo;
    logic ready_strobe_output;

    modport device_end (
        input  cs_n,
        input  sclk,
        input  sdi,
        output sdo,
        output ready_strobe_output
    );

    modport host_end (
        output cs_n,
        output sclk,
        output sdi,
        input  sdo,
        input  ready_strobe_output
    );
endinterface
`default_nettype wire

// ### logic/adc_spi_device.sv
// Converter end of the serial link: protocol select, command capture and result shifting.
`timescale 1ns/100ps
`default_nettype none
module adc_spi_device (
    // Link pins
    spi_link_if.device_end       link,
    // Clock and reset
    input  wire logic            link_clk,
    input  wire logic            hresetn,
    // Converter core
    input  wire logic [21:0]     conv_data,
    // Status
    output logic [1:0]           input_protocol_select,
    output logic [1:0]           output_protocol_select,
    output logic                 early_launch
);

    // ****************************************
    // Reset release and pin synchronisers
    // ****************************************
    logic [1:0]  rst_pipe_q;
    logic        rst_n;
    logic [2:0]  pin_meta_q;
    logic [2:0]  pin_sync_q;
    logic        cs_prev_q;
    logic        sclk_prev_q;

    // Reset is released on the link clock so no flop leaves reset on a half edge.
    always_ff @(posedge link_clk or negedge hresetn) begin
        if (!hresetn) begin
            rst_pipe_q <= 2'h0;
        end else begin
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe_q[1];

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_q  <= 3'h7;
            pin_sync_q  <= 3'h7;
            cs_prev_q   <= 1'b1;
            sclk_prev_q <= 1'b0;
        end else begin
            pin_meta_q  <= {link.cs_n, link.sclk, link.sdi};
            pin_sync_q  <= pin_meta_q;
            cs_prev_q   <= pin_sync_q[2];
            sclk_prev_q <= pin_sync_q[1];
        end
    end

    // ****************************************
    // Edge decode
    // ****************************************
    wire cs_s       = pin_sync_q[2];
    wire sclk_s     = pin_sync_q[1];
    wire sdi_s      = pin_sync_q[0];
    wire active     = ~cs_s;
    wire cs_fall    = cs_prev_q & ~cs_s;
    wire cs_rise    = ~cs_prev_q & cs_s;
    wire sclk_rise  = ~sclk_prev_q & sclk_s;
    wire sclk_fall  = sclk_prev_q & ~sclk_s;

    logic [7:0] in_ctrl_q;
    logic [7:0] out_ctrl_q;
    logic [1:0] fr_in_q;
    logic [1:0] fr_out_q;

    // Polarity equal to phase captures on rising edges, otherwise on falling ones.
    wire cap_on_rise = (fr_in_q[spi_link_pkg::MODE_CPOL] == fr_in_q[spi_link_pkg::MODE_CPHA]);
    wire cap_edge    = active & (cap_on_rise ? sclk_rise : sclk_fall);
    wire launch_edge = active & (cap_on_rise ? sclk_fall : sclk_rise);
    wire fr_early    = (fr_out_q == spi_link_pkg::OUT_EARLY) & ~fr_in_q[spi_link_pkg::MODE_CPHA];
    wire shift_edge  = fr_early ? cap_edge : launch_edge;
    wire fr_source   = (fr_out_q == spi_link_pkg::OUT_SOURCE);
    wire next_cpha   = in_ctrl_q[spi_link_pkg::MODE_CPHA];

    // The select fall still sees the last frame's shifter and mode, so the pins
    // wait one clock rather than flash a stale bit or strobe.
    wire in_frame    = active & ~cs_fall;

    // ****************************************
    // Frame protocol latch
    // ****************************************
    // The frame runs on the selection seen at its select fall, so a write that
    // lands at the end of a frame never disturbs that frame.
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            fr_in_q  <= spi_link_pkg::MODE_DEFAULT;
            fr_out_q <= spi_link_pkg::OUT_STANDARD;
        end else if (cs_fall) begin
            fr_in_q  <= in_ctrl_q[1:0];
            fr_out_q <= out_ctrl_q[1:0];
        end
    end

    // ****************************************
    // Command capture
    // ****************************************
    logic [21:0] in_sh_q;
    logic [4:0]  in_cnt_q;

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            in_sh_q  <= '0;
            in_cnt_q <= 5'h00;
        end else if (cs_fall) begin
            in_cnt_q <= 5'h00;
        end else if (cap_edge) begin
            in_sh_q <= {in_sh_q[spi_link_pkg::WORD_MSB-1:0], sdi_s};
            if (in_cnt_q != spi_link_pkg::WORD_COUNT) begin
                in_cnt_q <= in_cnt_q + 5'h01;
            end
        end
    end

    wire        word_full = (in_cnt_q == spi_link_pkg::WORD_COUNT);
    wire        is_write  = word_full & (in_sh_q[spi_link_pkg::CMD_MSB:spi_link_pkg::CMD_LSB] == spi_link_pkg::CMD_WRITE);
    wire [7:0]  wr_addr   = in_sh_q[spi_link_pkg::ADDR_MSB:spi_link_pkg::ADDR_LSB];
    wire [7:0]  wr_data   = in_sh_q[spi_link_pkg::DATA_MSB:0];
    wire        wr_in     = cs_rise & is_write & (wr_addr == spi_link_pkg::ADDR_IN_CTRL);
    wire        wr_out    = cs_rise & is_write & (wr_addr == spi_link_pkg::ADDR_OUT_CTRL);

    // ****************************************
    // Control registers
    // ****************************************
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            in_ctrl_q    <= spi_link_pkg::IN_CTRL_RESET;
            out_ctrl_q   <= spi_link_pkg::OUT_CTRL_RESET;
            early_launch <= 1'b0;
        end else begin
            if (wr_in) begin
                in_ctrl_q <= wr_data;
            end
            if (wr_out) begin
                out_ctrl_q <= wr_data;
            end
            // Status only: frames take early launch from their latched selection,
            // so the one-clock lag of this bit never reaches the pins.
            early_launch <= (out_ctrl_q[1:0] == spi_link_pkg::OUT_EARLY) & ~next_cpha;
        end
    end

    assign input_protocol_select  = in_ctrl_q[1:0];
    assign output_protocol_select = out_ctrl_q[1:0];

    // ****************************************
    // Result shifting and strobe pin
    // ****************************************
    logic [21:0] out_sh_q;
    logic        primed_q;
    logic        sdo_q;
    logic        strobe_q;

    // Phase-zero protocols present the first bit at select fall; phase-one
    // protocols hold it back until the first launch edge.
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_sh_q <= '0;
            primed_q <= 1'b0;
        end else if (cs_fall) begin
            out_sh_q <= conv_data;
            primed_q <= ~next_cpha;
        end else if (shift_edge) begin
            if (primed_q) begin
                out_sh_q <= {out_sh_q[spi_link_pkg::WORD_MSB-1:0], 1'b0};
            end else begin
                primed_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            sdo_q    <= 1'b0;
            strobe_q <= 1'b0;
        end else begin
            sdo_q    <= in_frame & primed_q & out_sh_q[spi_link_pkg::WORD_MSB];
            strobe_q <= in_frame & fr_source & sclk_s;
        end
    end

    // ****************************************
    // Pin drivers
    // ****************************************
    assign link.sdo                 = sdo_q;
    assign link.ready_strobe_output = strobe_q;

endmodule
`default_nettype wire

// ### logic/adc_spi_host.sv
// Host end of the serial link: bus registers, serial clock divider and frame sequencer.
//
// Register access over AHB-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module adc_spi_host #(
    parameter int HALF_CYCLES = spi_link_pkg::SCLK_HALF_CYCLES
) (
    // Clock and reset
    input  wire logic            hclk,
    input  wire logic            hresetn,
    // Bus slave
    input  wire logic            hsel,
    input  wire logic [31:0]     haddr,
    input  wire logic [1:0]      htrans,
    input  wire logic            hwrite,
    input  wire logic [2:0]      hsize,
    input  wire logic [31:0]     hwdata,
    input  wire logic            hready,
    output logic                 hreadyout,
    output logic                 hresp,
    output logic [31:0]          hrdata,
    // Link pins
    spi_link_if.host_end         link
);

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_LEAD  = 4'b0010,
        ST_CLOCK = 4'b0100,
        ST_TAIL  = 4'b1000
    } seq_state_e;

    localparam logic [7:0] HALF_LAST = 8'(HALF_CYCLES - 1);

    // ****************************************
    // Bus slave
    // ****************************************
    logic        dp_wr_q;
    logic [7:0]  dp_addr_q;
    logic [31:0] hrdata_q;
    logic [21:0] tx_q;
    logic [21:0] rx_q;
    logic [4:0]  len_q;
    logic [1:0]  trk_in_q;
    logic [1:0]  trk_out_q;
    seq_state_e  state_q;

    wire        addr_phase = hsel & (htrans == spi_link_pkg::HTRANS_NONSEQ) & hready;
    wire [7:0]  ap_addr    = haddr[7:0];
    wire        busy       = (state_q != ST_IDLE);
    wire [31:0] status_w   = {27'h0, trk_out_q, trk_in_q, busy};
    wire [31:0] rd_mux     = (ap_addr == spi_link_pkg::REG_TX)        ? {10'h0, tx_q} :
                             (ap_addr == spi_link_pkg::REG_RX)        ? {10'h0, rx_q} :
                             (ap_addr == spi_link_pkg::REG_STATUS)    ? status_w :
                             (ap_addr == spi_link_pkg::REG_FRAME_LEN) ? {27'h0, len_q} : 32'h0;
    wire        wr_tx      = dp_wr_q & (dp_addr_q == spi_link_pkg::REG_TX) & ~busy;
    wire        wr_len     = dp_wr_q & (dp_addr_q == spi_link_pkg::REG_FRAME_LEN) & ~busy;
    // A start while a frame runs is dropped; software polls the busy bit.
    wire        start      = dp_wr_q & (dp_addr_q == spi_link_pkg::REG_CTRL)
                             & hwdata[spi_link_pkg::CTRL_START] & ~busy;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_q   <= 1'b0;
            dp_addr_q <= 8'h00;
            hrdata_q  <= 32'h0;
        end else begin
            dp_wr_q <= addr_phase & hwrite;
            if (addr_phase) begin
                dp_addr_q <= ap_addr;
                hrdata_q  <= rd_mux;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_q  <= '0;
            len_q <= spi_link_pkg::FRAME_LEN_RESET;
        end else begin
            if (wr_tx) begin
                tx_q <= hwdata[spi_link_pkg::WORD_MSB:0];
            end
            if (wr_len) begin
                len_q <= hwdata[spi_link_pkg::LEN_W-1:0];
            end
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    // ****************************************
    // Frame sequencer
    // ****************************************
    logic        sdo_meta_q;
    logic        sdo_sync_q;
    logic [7:0]  tmr_q;
    logic [5:0]  edge_q;
    logic [1:0]  fr_mode_q;
    logic [21:0] tx_sh_q;
    logic [21:0] rx_sh_q;
    logic        sclk_q;
    logic        cs_n_q;
    logic        sdi_q;

    wire       tick       = (tmr_q == HALF_LAST);
    wire [5:0] last_edge  = {len_q, 1'b0} - 6'h01;
    wire       cpha       = fr_mode_q[spi_link_pkg::MODE_CPHA];
    wire       clk_step   = (state_q == ST_CLOCK) & tick;
    wire       cap_step   = clk_step & (edge_q[0] == cpha);
    wire       lau_step   = clk_step & (edge_q[0] != cpha);
    wire       long_frame = (len_q >= spi_link_pkg::WORD_COUNT);
    wire       sent_write = long_frame & (tx_q[spi_link_pkg::CMD_MSB:spi_link_pkg::CMD_LSB] == spi_link_pkg::CMD_WRITE);
    wire [7:0] sent_addr  = tx_q[spi_link_pkg::ADDR_MSB:spi_link_pkg::ADDR_LSB];
    wire       frame_end  = (state_q == ST_TAIL) & tick;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sdo_meta_q <= 1'b0;
            sdo_sync_q <= 1'b0;
        end else begin
            sdo_meta_q <= link.sdo;
            sdo_sync_q <= sdo_meta_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= ST_IDLE;
            tmr_q   <= 8'h00;
            edge_q  <= 6'h00;
        end else begin
            tmr_q <= (state_q == ST_IDLE || tick) ? 8'h00 : tmr_q + 8'h01;
            unique case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        state_q <= ST_LEAD;
                    end
                end
                ST_LEAD: begin
                    edge_q <= 6'h00;
                    if (tick) begin
                        state_q <= ST_CLOCK;
                    end
                end
                ST_CLOCK: begin
                    if (tick) begin
                        edge_q <= edge_q + 6'h01;
                        if (edge_q == last_edge) begin
                            state_q <= ST_TAIL;
                        end
                    end
                end
                ST_TAIL: begin
                    if (tick) begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // The host follows its own writes to the converter's select registers, so the
    // frame that changes the protocol still runs on the old one.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trk_in_q  <= spi_link_pkg::MODE_DEFAULT;
            trk_out_q <= spi_link_pkg::OUT_STANDARD;
            fr_mode_q <= spi_link_pkg::MODE_DEFAULT;
            rx_q      <= '0;
        end else begin
            if (start) begin
                fr_mode_q <= trk_in_q;
            end
            if (frame_end) begin
                rx_q <= rx_sh_q;
                if (sent_write && sent_addr == spi_link_pkg::ADDR_IN_CTRL) begin
                    trk_in_q <= tx_q[1:0];
                end
                if (sent_write && sent_addr == spi_link_pkg::ADDR_OUT_CTRL) begin
                    trk_out_q <= tx_q[1:0];
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sclk_q  <= 1'b0;
            cs_n_q  <= 1'b1;
            sdi_q   <= 1'b0;
            tx_sh_q <= '0;
            rx_sh_q <= '0;
        end else if (state_q == ST_IDLE) begin
            sclk_q <= trk_in_q[spi_link_pkg::MODE_CPOL];
            if (start) begin
                cs_n_q <= 1'b0;
                rx_sh_q <= '0;
                if (!trk_in_q[spi_link_pkg::MODE_CPHA]) begin
                    sdi_q   <= tx_q[spi_link_pkg::WORD_MSB];
                    tx_sh_q <= {tx_q[spi_link_pkg::WORD_MSB-1:0], 1'b0};
                end else begin
                    tx_sh_q <= tx_q;
                end
            end
        end else begin
            if (clk_step) begin
                sclk_q <= ~sclk_q;
            end
            if (cap_step) begin
                rx_sh_q <= {rx_sh_q[spi_link_pkg::WORD_MSB-1:0], sdo_sync_q};
            end
            if (lau_step) begin
                sdi_q   <= tx_sh_q[spi_link_pkg::WORD_MSB];
                tx_sh_q <= {tx_sh_q[spi_link_pkg::WORD_MSB-1:0], 1'b0};
            end
            if (frame_end) begin
                cs_n_q <= 1'b1;
                sdi_q  <= 1'b0;
            end
        end
    end

    assign link.cs_n = cs_n_q;
    assign link.sclk = sclk_q;
    assign link.sdi  = sdi_q;

endmodule
`default_nettype wire

// ### tb/adc_spi_protocol_select_assertions.sv
// Concurrent checks on the serial link between host and converter ends.
`timescale 1ns/100ps
`default_nettype none
module adc_spi_protocol_select_assertions (
    // Clocks and reset
    input wire logic       hclk,
    input wire logic       link_clk,
    input wire logic       hresetn,
    // Link pins
    input wire logic       cs_n,
    input wire logic       sclk,
    input wire logic       sdi,
    input wire logic       sdo,
    input wire logic       ready_strobe_output,
    // Converter status
    input wire logic [1:0] input_protocol_select,
    input wire logic [1:0] output_protocol_select,
    input wire logic       early_launch
);
    // ****************************************
    // Frame steps
    // ****************************************
    sequence frame_open;
        $fell(cs_n);
    endsequence
    sequence two_low;
        !cs_n ##1 !cs_n;
    endsequence

    // ****************************************
    // Checks
    // ****************************************
    chk_idle_clk_level: assert property (@(posedge hclk) disable iff (!hresetn)
        frame_open |-> sclk == input_protocol_select[1]) else $error("sclk idle level wrong at frame start");
    chk_reset_default: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(hresetn) |-> input_protocol_select == 2'h0 && output_protocol_select == 2'h0)
        else $error("selects not default after reset");
    chk_sdi_launch_only: assert property (@(posedge hclk) disable iff (!hresetn)
        (!cs_n && !$fell(cs_n) && $changed(sdi)) |-> $changed(sclk)) else $error("sdi moved off a clock edge");
    chk_lead_zero_cpha: assert property (@(posedge hclk) disable iff (!hresetn)
        (frame_open and input_protocol_select[0]) |-> ##4 (!sdo) [*3]) else $error("sdo early in phase one mode");
    chk_early_on: assert property (@(posedge link_clk) disable iff (!hresetn)
        (output_protocol_select == 2'h1 && !input_protocol_select[0]) [*2] |-> early_launch)
        else $error("early launch not enabled");
    chk_early_blocked: assert property (@(posedge link_clk) disable iff (!hresetn)
        input_protocol_select[0] [*2] |-> !early_launch) else $error("early launch in phase one mode");
    chk_echo_strobe: assert property (@(posedge hclk) disable iff (!hresetn)
        ($rose(sclk) && !cs_n && output_protocol_select == 2'h3) |-> ##[0:4] ready_strobe_output)
        else $error("strobe does not echo clock");
    chk_strobe_low: assert property (@(posedge hclk) disable iff (!hresetn)
        (!cs_n && output_protocol_select != 2'h3) |-> !ready_strobe_output) else $error("strobe high in frame");
    chk_select_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        two_low |-> $stable(input_protocol_select) && $stable(output_protocol_select))
        else $error("select changed inside a frame");
endmodule
`default_nettype wire

// ### tb/adc_spi_protocol_select_bench.sv
// Bench joining the host and converter ends over one link, driven from the system bus.
`timescale 1ns/100ps
`default_nettype none
module adc_spi_protocol_select_bench;
    logic        hclk;
    logic        link_clk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [21:0] conv_data;
    logic [1:0]  input_protocol_select;
    logic [1:0]  output_protocol_select;
    logic        early_launch;
    logic [31:0] rd;
    logic [1:0]  ms;
    int          error_cnt;
    int          checked;

    spi_link_if link_bus ();

    adc_spi_host adc_spi_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .link(link_bus));
    adc_spi_device adc_spi_device_inst (.link(link_bus), .link_clk(link_clk), .hresetn(hresetn),
        .conv_data(conv_data), .input_protocol_select(input_protocol_select),
        .output_protocol_select(output_protocol_select), .early_launch(early_launch));
    adc_spi_protocol_select_assertions adc_spi_protocol_select_assertions_inst (.hclk(hclk),
        .link_clk(link_clk), .hresetn(hresetn), .cs_n(link_bus.cs_n), .sclk(link_bus.sclk), .sdi(link_bus.sdi),
        .sdo(link_bus.sdo), .ready_strobe_output(link_bus.ready_strobe_output),
        .input_protocol_select(input_protocol_select), .output_protocol_select(output_protocol_select),
        .early_launch(early_launch));

    // ****************************************
    // Clocks, expectations and bus tasks
    // ****************************************
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    // The link clock starts off phase at a 48 ns period, so its edges drift against hclk and meet one only once every 600 ns.
    initial begin
        link_clk = 1'b0;
        #7;
        forever #24 link_clk = ~link_clk;
    end

    function automatic logic [21:0] cmd(input logic [7:0] a, input logic [7:0] d);
        cmd = {spi_link_pkg::CMD_WRITE, 3'h0, a, d};
    endfunction
    function automatic logic [31:0] exp_rx(input logic [21:0] v, input logic [4:0] len);
        exp_rx = {10'h0, v} >> (spi_link_pkg::WORD_BITS - int'(len));
    endfunction

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t word got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_sel(input logic [1:0] got, input logic [1:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t select got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= spi_link_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    // Frames are polled to completion; the idle wait covers the converter's select recovery.
    task automatic frame(input logic [21:0] tx);
        int n;
        bus(1'b1, spi_link_pkg::REG_TX, {10'h0, tx});
        bus(1'b1, spi_link_pkg::REG_CTRL, 32'h1);
        repeat (2) @(posedge hclk);
        n = 0;
        do begin
            bus(1'b0, spi_link_pkg::REG_STATUS, 32'h0);
            n++;
        end while (rd[spi_link_pkg::STAT_BUSY] !== 1'b0 && n < 2000);
        if (n == 2000) error_cnt++;
        repeat (8) @(posedge hclk);
        bus(1'b0, spi_link_pkg::REG_RX, 32'h0);
    endtask

    task automatic read_chk(input logic [4:0] len);
        logic [21:0] v;
        v = 22'($urandom);
        conv_data <= v;
        frame(22'h0);
        cmp_word(rd, exp_rx(v, len));
    endtask

    task automatic do_reset();
        hresetn <= 1'b0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (10) @(posedge hclk);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        conv_data = 22'h0;
        hresetn = 1'b0;
        error_cnt = 0;
        checked = 0;
        rd = $urandom(32'h24ef6c84);
        do_reset();
        bus(1'b0, spi_link_pkg::REG_STATUS, 32'h0);
        cmp_word(rd, 32'h0);
        cmp_sel({hreadyout, hresp}, 2'h2);
        bus(1'b0, spi_link_pkg::REG_FRAME_LEN, 32'h0);
        cmp_word(rd, {27'h0, spi_link_pkg::FRAME_LEN_RESET});
        bus(1'b1, 8'h14, 32'hffffffff);
        bus(1'b0, 8'h14, 32'h0);
        cmp_word(rd, 32'h0);
        $display("test reset values done");
        for (int m = 0; m < 4; m++) begin
            ms = 2'(m);
            frame(cmd(spi_link_pkg::ADDR_IN_CTRL, {6'h0, ms}));
            repeat (8) @(posedge hclk);
            cmp_sel(input_protocol_select, ms);
            bus(1'b0, spi_link_pkg::REG_STATUS, 32'h0);
            cmp_word(rd, {27'h0, 2'h0, ms, 1'b0});
            read_chk(5'h16);
            frame(cmd(spi_link_pkg::ADDR_OUT_CTRL, {6'h0, spi_link_pkg::OUT_EARLY}));
            repeat (8) @(posedge hclk);
            cmp_sel({1'b0, early_launch}, {1'b0, ~ms[0]});
            read_chk(5'h16);
            frame(cmd(spi_link_pkg::ADDR_OUT_CTRL, {6'h0, spi_link_pkg::OUT_SOURCE}));
            frame(cmd(spi_link_pkg::ADDR_OUT_CTRL, {6'h0, spi_link_pkg::OUT_STANDARD}));
            repeat (8) @(posedge hclk);
            cmp_sel(output_protocol_select, spi_link_pkg::OUT_STANDARD);
            $display("test mode %0d done", m);
        end
        do_reset();
        cmp_sel(input_protocol_select, spi_link_pkg::MODE_DEFAULT);
        cmp_sel(output_protocol_select, spi_link_pkg::OUT_STANDARD);
        bus(1'b1, spi_link_pkg::REG_FRAME_LEN, 32'h14);
        read_chk(5'h14);
        // A write one clock short must leave the converter in its default protocol.
        bus(1'b1, spi_link_pkg::REG_FRAME_LEN, 32'h15);
        frame(cmd(spi_link_pkg::ADDR_IN_CTRL, 8'h02));
        repeat (8) @(posedge hclk);
        cmp_sel(input_protocol_select, spi_link_pkg::MODE_DEFAULT);
        $display("test short frames done");
        test_done();
    end

    initial begin
        repeat (60000) @(posedge hclk);
        error_cnt++;
        test_done();
    end
endmodule
`default_nettype wire
